/* File: sfh_consts.svh */
// constants for the serial memory host controller
`ifndef SFH_CONSTS_SVH
`define SFH_CONSTS_SVH

// ----------------------------------------------------------------
// timing, in nanoseconds
// ----------------------------------------------------------------
`define SFH_CLK_NS 25
`define SFH_T_HALF_NS 500
`define SFH_T_LEAD_NS 500
`define SFH_T_LAG_NS 500
`define SFH_T_GAP_NS 2000
`define SFH_T_PUR_NS 1000000
`define SFH_T_PUW_NS 5000000

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define SFH_OFF_CTRL 12'h000
`define SFH_OFF_ADDR 12'h004
`define SFH_OFF_STAT 12'h008
`define SFH_BUF_PAGE 7'h01
`define SFH_CTRL_START 0
`define SFH_CTRL_CMD_LSB 1
`define SFH_CTRL_PAUSE 4
`define SFH_CTRL_LEN_LSB 8
`define SFH_ADDR_SR_LSB 16

// ----------------------------------------------------------------
// device opcodes and frame shape
// ----------------------------------------------------------------
`define SFH_OP_SET_LATCH 8'h06
`define SFH_OP_CLR_LATCH 8'h04
`define SFH_OP_STAT_READ 8'h05
`define SFH_OP_STAT_PROG 8'h01
`define SFH_OP_ARRAY_READ 8'h03
`define SFH_OP_ARRAY_PROG 8'h02
`define SFH_SR_KEEP 8'h8C
`define SFH_PROG_BYTES 6'h20
`define SFH_HDR_BYTES 6'h03

`endif

/* File: sfh_pkg.sv */
// types shared by the serial memory host controller
package sfh_pkg;

  typedef enum logic [2:0] {
    SFH_SET_LATCH,
    SFH_CLR_LATCH,
    SFH_STAT_READ,
    SFH_STAT_PROG,
    SFH_ARRAY_READ,
    SFH_ARRAY_PROG
  } sfh_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GAP,
    ST_LEAD,
    ST_SHIFT,
    ST_LAG
  } sfh_state_t;

  typedef struct packed {
    logic select_n;
    logic sck;
    logic mosi;
    logic pause_n;
  } sfh_pins_t;

endpackage : sfh_pkg

/* File: sfh_sync.sv */
// two-flop synchroniser for a pin input
`timescale 1ns/1ps
module sfh_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  logic meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule : sfh_sync

/* File: sfh_sck_gen.sv */
// serial clock divider giving rise and fall moments
`timescale 1ns/1ps
`include "sfh_consts.svh"
module sfh_sck_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  output logic rise_go,
  output logic fall_go
);
  localparam int HALF_CYC = (`SFH_T_HALF_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS;
  logic high;
  logic [4:0] cnt;
  wire last = cnt == 5'(HALF_CYC - 1);

  // en only gates the low phase, so a stop always lands with sck low
  assign rise_go = ~high & en & last;
  assign fall_go = high & last;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high <= 1'b0;
      cnt <= 5'h00;
    end
    else if (high | en)
    begin
      cnt <= last ? 5'h00 : cnt + 5'h01;
      if (last)
        high <= ~high;
    end
    else
      cnt <= 5'h00;
  end
endmodule : sfh_sck_gen

/* File: sfh_host.sv */
// apb-driven host controller for a serial nonvolatile memory
// Function
// - shift input on rising sck, device output sampled on rising sck
// - array read: opcode, 16-bit address, then data bytes out
// - read ends only by raising select
// - programming needs a prior separate latch-set frame
// - latch-set frame is exactly eight bits, then select high
// - array program: select low for opcode, address, 256 data clocks
// - exactly 32 data bytes from a sector-aligned start
// - status program data bits 0,1,4,5,6 sent as zero
// - pause changes only while sck is low
// - wait 1 ms before reads, 5 ms before writes after power-up
// - opcodes: set latch 06, array read 03, array program 02
// - opcodes: clear latch 04, status read 05, status program 01
`timescale 1ns/1ps
`include "sfh_consts.svh"
module sfh_host #(
  parameter int PUR_CYCLES = (`SFH_T_PUR_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS,
  parameter int PUW_CYCLES = (`SFH_T_PUW_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic miso,
  output sfh_pkg::sfh_pins_t spi_out
);
  localparam int LEAD_CYC = (`SFH_T_LEAD_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS;
  localparam int LAG_CYC = (`SFH_T_LAG_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS;
  localparam int GAP_CYC = (`SFH_T_GAP_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] opcode_of(input sfh_pkg::sfh_cmd_t c);
    case (c)
      sfh_pkg::SFH_SET_LATCH: opcode_of = `SFH_OP_SET_LATCH;
      sfh_pkg::SFH_CLR_LATCH: opcode_of = `SFH_OP_CLR_LATCH;
      sfh_pkg::SFH_STAT_READ: opcode_of = `SFH_OP_STAT_READ;
      sfh_pkg::SFH_STAT_PROG: opcode_of = `SFH_OP_STAT_PROG;
      sfh_pkg::SFH_ARRAY_READ: opcode_of = `SFH_OP_ARRAY_READ;
      sfh_pkg::SFH_ARRAY_PROG: opcode_of = `SFH_OP_ARRAY_PROG;
      default: opcode_of = `SFH_OP_STAT_READ;
    endcase
  endfunction : opcode_of

  function automatic logic is_write(input sfh_pkg::sfh_cmd_t c);
    is_write = (c != sfh_pkg::SFH_STAT_READ) &&
               (c != sfh_pkg::SFH_ARRAY_READ);
  endfunction : is_write

  function automatic logic is_prog(input sfh_pkg::sfh_cmd_t c);
    is_prog = (c == sfh_pkg::SFH_STAT_PROG) ||
              (c == sfh_pkg::SFH_ARRAY_PROG);
  endfunction : is_prog

  function automatic logic [5:0] frame_bytes(input sfh_pkg::sfh_cmd_t c,
                                             input logic [4:0] n);
    if (c == sfh_pkg::SFH_ARRAY_READ)
      frame_bytes = `SFH_HDR_BYTES + {1'b0, n} + 6'h01;
    else if (c == sfh_pkg::SFH_ARRAY_PROG)
      frame_bytes = `SFH_HDR_BYTES + `SFH_PROG_BYTES;
    else if (is_write(c) && !is_prog(c))
      frame_bytes = 6'h01;
    else
      frame_bytes = 6'h02;
  endfunction : frame_bytes

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfh_pkg::sfh_state_t state;
  sfh_pkg::sfh_cmd_t op, main_cmd, cmd;
  logic pre, done, pause_req, miso_s, rise_go, fall_go, latch_sent;
  logic [6:0] cnt;
  logic [5:0] byte_idx, nbytes;
  logic [2:0] bit_idx;
  logic [7:0] tx_sr, rx_sr, sr_data, stat_byte;
  logic [4:0] len;
  logic [15:0] addr_q;
  logic [17:0] pu_cnt;
  logic [9:0] rise_cnt;
  logic [7:0] buf_mem [0:31];

  sfh_sync u_miso_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(miso),
    .dout(miso_s)
  );

  wire gen_en = (state == sfh_pkg::ST_SHIFT) & spi_out.pause_n & ~pause_req;

  sfh_sck_gen u_sck_gen (
    .pclk(pclk),
    .presetn(presetn),
    .en(gen_en),
    .rise_go(rise_go),
    .fall_go(fall_go)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire aligned = paddr[1:0] == 2'h0;
  wire sel_ctrl = paddr == `SFH_OFF_CTRL;
  wire sel_addr = paddr == `SFH_OFF_ADDR;
  wire sel_stat = paddr == `SFH_OFF_STAT;
  wire sel_buf = (paddr[11:5] == `SFH_BUF_PAGE) & aligned;
  wire hit = sel_ctrl | sel_addr | sel_stat | sel_buf;
  wire acc = psel & penable & ~pready;
  wire wr_now = psel & penable & pready & pwrite & ~pslverr;
  wire wr_ctrl = wr_now & sel_ctrl;
  wire wr_addr = wr_now & sel_addr;
  wire wr_buf = wr_now & sel_buf;
  wire busy = state != sfh_pkg::ST_IDLE;
  wire pur_ok = pu_cnt >= 18'(PUR_CYCLES);
  wire puw_ok = pu_cnt >= 18'(PUW_CYCLES);
  wire [4:0] bw = {paddr[4:2], 2'h0};
  wire [31:0] ctrl_rd = {19'h00000, len, 3'h0, pause_req, cmd, 1'b0};
  wire [31:0] addr_rd = {8'h00, sr_data, addr_q};
  wire [31:0] stat_rd = {16'h0000, stat_byte, 4'h0, done, puw_ok, pur_ok,
                         busy};
  wire [31:0] buf_rd = {buf_mem[bw + 5'h03], buf_mem[bw + 5'h02],
                        buf_mem[bw + 5'h01], buf_mem[bw]};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_rd : sel_addr ? addr_rd :
                       sel_stat ? stat_rd : sel_buf ? buf_rd : 32'h0000_0000;
  wire sfh_pkg::sfh_cmd_t new_cmd =
    sfh_pkg::sfh_cmd_t'(pwdata[`SFH_CTRL_CMD_LSB +: 3]);
  wire go = wr_ctrl & pwdata[`SFH_CTRL_START] & ~busy & (cnt == 7'h00) &
            (new_cmd <= sfh_pkg::SFH_ARRAY_PROG) &
            (is_write(new_cmd) ? puw_ok : pur_ok);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc & ~hit;
      prdata <= (acc & hit & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd <= sfh_pkg::SFH_STAT_READ;
      len <= 5'h00;
      pause_req <= 1'b0;
      pu_cnt <= 18'h00000;
    end
    else
    begin
      if (!puw_ok)
        pu_cnt <= pu_cnt + 18'h00001;
      if (wr_ctrl)
      begin
        cmd <= new_cmd;
        len <= pwdata[`SFH_CTRL_LEN_LSB +: 5];
        pause_req <= pwdata[`SFH_CTRL_PAUSE];
      end
    end
  end

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  wire [5:0] nb = byte_idx + 6'h01;
  wire [4:0] di = 5'(nb - `SFH_HDR_BYTES);
  wire [4:0] ri = 5'(byte_idx - `SFH_HDR_BYTES);
  wire [7:0] op_byte = opcode_of(op);
  wire [15:0] tx_addr = (op == sfh_pkg::SFH_ARRAY_PROG) ?
                        {addr_q[15:5], 5'h00} : addr_q;
  // reserved status bits forced to zero
  wire [7:0] tx_next = (op == sfh_pkg::SFH_STAT_PROG) ? sr_data & `SFH_SR_KEEP :
                       (nb == 6'h01) ? tx_addr[15:8] :
                       (nb == 6'h02) ? tx_addr[7:0] :
                       (op == sfh_pkg::SFH_ARRAY_PROG) ? buf_mem[di] : 8'h00;
  wire byte_end = (state == sfh_pkg::ST_SHIFT) & fall_go & (bit_idx == 3'h7);
  wire rx_store = byte_end & (op == sfh_pkg::SFH_ARRAY_READ) &
                  (byte_idx >= `SFH_HDR_BYTES);

  always_ff @(posedge pclk)
  begin
    if (wr_buf)
      for (int i = 0; i < 4; i++)
        buf_mem[bw + 5'(i)] <= pwdata[8*i +: 8];
    else if (rx_store)
      buf_mem[ri] <= rx_sr;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= sfh_pkg::ST_IDLE;
      op <= sfh_pkg::SFH_STAT_READ;
      main_cmd <= sfh_pkg::SFH_STAT_READ;
      pre <= 1'b0;
      done <= 1'b0;
      cnt <= 7'h00;
      byte_idx <= 6'h00;
      nbytes <= 6'h00;
      bit_idx <= 3'h0;
      tx_sr <= 8'h00;
      rx_sr <= 8'h00;
      stat_byte <= 8'h00;
      addr_q <= 16'h0000;
      sr_data <= 8'h00;
      rise_cnt <= 10'h000;
      latch_sent <= 1'b0;
      spi_out <= 4'b1001;
    end
    else
    begin
      if (wr_addr)
      begin
        addr_q <= pwdata[15:0];
        sr_data <= pwdata[`SFH_ADDR_SR_LSB +: 8];
      end
      // pause moves only with sck low
      if (!spi_out.sck)
        spi_out.pause_n <= ~(pause_req & (state == sfh_pkg::ST_SHIFT));
      unique case (state)
        sfh_pkg::ST_IDLE:
        begin
          if (cnt != 7'h00)
            cnt <= cnt - 7'h01;
          if (go)
          begin
            op <= is_prog(new_cmd) ? sfh_pkg::SFH_SET_LATCH : new_cmd;
            pre <= is_prog(new_cmd);
            main_cmd <= new_cmd;
            done <= 1'b0;
            state <= sfh_pkg::ST_GAP;
          end
        end
        sfh_pkg::ST_GAP:
        begin
          if (cnt != 7'h00)
            cnt <= cnt - 7'h01;
          else
          begin
            spi_out.select_n <= 1'b0;
            spi_out.mosi <= op_byte[7];
            tx_sr <= op_byte;
            byte_idx <= 6'h00;
            bit_idx <= 3'h0;
            nbytes <= frame_bytes(op, len);
            rise_cnt <= 10'h000;
            cnt <= 7'(LEAD_CYC - 1);
            state <= sfh_pkg::ST_LEAD;
          end
        end
        sfh_pkg::ST_LEAD:
        begin
          cnt <= cnt - 7'h01;
          if (cnt == 7'h00)
            state <= sfh_pkg::ST_SHIFT;
        end
        sfh_pkg::ST_SHIFT:
        begin
          // sample on rise, shift out on fall
          if (rise_go)
          begin
            spi_out.sck <= 1'b1;
            rx_sr <= {rx_sr[6:0], miso_s};
            rise_cnt <= rise_cnt + 10'h001;
          end
          if (fall_go)
          begin
            spi_out.sck <= 1'b0;
            if (bit_idx != 3'h7)
            begin
              bit_idx <= bit_idx + 3'h1;
              tx_sr <= {tx_sr[6:0], 1'b0};
              spi_out.mosi <= tx_sr[6];
            end
            else if (nb != nbytes)
            begin
              bit_idx <= 3'h0;
              byte_idx <= nb;
              tx_sr <= tx_next;
              spi_out.mosi <= tx_next[7];
            end
            else
            begin
              cnt <= 7'(LAG_CYC - 1);
              state <= sfh_pkg::ST_LAG;
            end
            if (op == sfh_pkg::SFH_STAT_READ)
              stat_byte <= rx_sr;
          end
        end
        sfh_pkg::ST_LAG:
        begin
          cnt <= cnt - 7'h01;
          if (cnt == 7'h00)
          begin
            // select rises only after the last bit
            spi_out.select_n <= 1'b1;
            spi_out.mosi <= 1'b0;
            cnt <= 7'(GAP_CYC - 1);
            if (op == sfh_pkg::SFH_SET_LATCH)
              latch_sent <= 1'b1;
            else if (is_prog(op) || op == sfh_pkg::SFH_CLR_LATCH)
              latch_sent <= 1'b0;
            if (pre)
            begin
              pre <= 1'b0;
              op <= main_cmd;
              state <= sfh_pkg::ST_GAP;
            end
            else
            begin
              done <= 1'b1;
              // next read address, wrapping at the top
              if (op == sfh_pkg::SFH_ARRAY_READ)
                addr_q <= addr_q + {11'h000, len} + 16'h0001;
              state <= sfh_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mosi_rise_stable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(spi_out.sck) |-> $stable(spi_out.mosi)) else $error("mosi moved at sck rise");
  a_sel_sck_low: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(spi_out.select_n) |-> !spi_out.sck && $past(!spi_out.sck))
    else $error("select moved with sck high");
  a_pause_sck_low: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(spi_out.pause_n) |-> !spi_out.sck && $past(!spi_out.sck))
    else $error("pause moved with sck high");
  a_pause_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !spi_out.pause_n [*2] |-> $stable(spi_out.sck) && $stable(spi_out.mosi))
    else $error("lines moved while paused");
  a_read_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(spi_out.select_n) |-> pu_cnt >= 18'(PUR_CYCLES))
    else $error("frame before read wait");
  a_write_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(spi_out.select_n) && is_write(op) |-> pu_cnt >= 18'(PUW_CYCLES))
    else $error("write before write wait");
  a_latch_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(spi_out.select_n) && $past(op) == sfh_pkg::SFH_SET_LATCH |->
    rise_cnt == 10'd8)
    else $error("latch frame not eight clocks");
  a_prog_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(spi_out.select_n) && $past(op) == sfh_pkg::SFH_ARRAY_PROG |->
    rise_cnt == 10'd280) else $error("program frame length wrong");
  a_read_len: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(spi_out.select_n) && op == sfh_pkg::SFH_ARRAY_READ |->
    rise_cnt == {2'h0, len, 3'h0} + 10'd32) else $error("read frame length wrong");
  a_latch_first: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(spi_out.select_n) && is_prog(op) |-> latch_sent)
    else $error("program without latch frame");
  a_sr_mask: assert property (@(posedge pclk) disable iff (!presetn)
    state == sfh_pkg::ST_SHIFT && op == sfh_pkg::SFH_STAT_PROG && byte_idx == 6'h01
    && bit_idx == 3'h0 |-> (tx_sr & ~`SFH_SR_KEEP) == 8'h00)
    else $error("status data reserved bits set");
  a_opcode_first: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(spi_out.select_n) |-> tx_sr == opcode_of(op) && spi_out.mosi == tx_sr[7])
    else $error("opcode not sent first");
endmodule : sfh_host

/* File: sfh_dev_model.sv */
// behavioural model of the serial nonvolatile memory device
`timescale 1ns/1ps
module sfh_dev_model #(
  parameter int PROG_NS = 50000
) (
  input wire logic select_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic pause_n,
  output logic miso
);
  logic [7:0] mem [0:65535];
  logic [7:0] pbuf [0:31];
  logic [31:0] acc;
  logic [7:0] op;
  logic [7:0] sr_nv;
  logic [7:0] cur;
  logic [15:0] addr;
  logic latch;
  logic busy;
  logic armed;
  int cnt;
  int b;

  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'(i >> 8);
    latch = 1'b0;
    busy = 1'b0;
    armed = 1'b0;
    sr_nv = 8'h00;
    miso = 1'b0;
    op = 8'h00;
    cnt = 0;
  end

  always @(negedge select_n)
  begin
    cnt = 0;
    armed = 1'b1;
  end

  always @(posedge sck)
  begin
    if (!select_n && pause_n && armed)
    begin
      acc = {acc[30:0], mosi};
      cnt++;
      if (cnt == 8) op = acc[7:0];
      if (cnt == 24) addr = acc[15:0];
      if (op == 8'h02 && cnt >= 32 && cnt % 8 == 0 && cnt <= 280)
        pbuf[(cnt - 32) / 8] = acc[7:0];
    end
  end

  always @(negedge sck)
  begin
    if (!select_n && pause_n && armed)
    begin
      b = 7 - cnt % 8;
      cur = busy ? 8'hFF : {sr_nv[7:2], latch, 1'b0};
      if (op == 8'h03) cur = mem[16'(addr + 16'((cnt - 24) / 8))];
      if ((op == 8'h05 && cnt >= 8) || (op == 8'h03 && cnt >= 24))
        miso = cur[b];
    end
  end

  always @(posedge select_n)
  begin
    miso = ~miso;
    if (armed && !busy && cnt == 8 && op == 8'h06) latch = 1'b1;
    if (armed && !busy && cnt == 8 && op == 8'h04) latch = 1'b0;
    if (latch && !busy && cnt == 280 && op == 8'h02)
    begin
      for (int i = 0; i < 32; i++)
        mem[{addr[15:5], 5'(i)}] = pbuf[i];
      busy = 1'b1;
    end
    if (latch && !busy && cnt == 16 && op == 8'h01)
    begin
      sr_nv = acc[7:0];
      busy = 1'b1;
    end
  end

  always @(posedge busy)
  begin
    #(PROG_NS);
    busy = 1'b0;
    latch = 1'b0;
  end
endmodule : sfh_dev_model

/* File: tb_top.sv */
// self-checking testbench for the serial memory host controller
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic miso;
  sfh_pkg::sfh_pins_t spi_out;
  logic [31:0] r;
  logic [31:0] v;
  logic e;
  logic [7:0] s;
  logic [15:0] a;
  logic [7:0] em [0:65535];
  int failures = 0;
  int tests_run = 0;

  always #12.5 pclk = ~pclk;

  sfh_host #(.PUR_CYCLES(20), .PUW_CYCLES(50)) sfh_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .miso(miso), .spi_out(spi_out)
  );

  sfh_dev_model sfh_dev_model_i (
    .select_n(spi_out.select_n), .sck(spi_out.sck),
    .mosi(spi_out.mosi), .pause_n(spi_out.pause_n), .miso(miso)
  );

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic run(input logic [2:0] c, input logic [4:0] l,
                     input logic wt);
    apb(1'h1, 12'h000, {19'h0, l, 3'h0, 1'h0, c, 1'h1});
    if (wt)
    begin
      do
        apb(1'h0, 12'h008, 32'h0);
      while (r[3] !== 1'b1);
      repeat (100) @(posedge pclk);
    end
  endtask : run

  task automatic sr;
    run(3'h2, 5'h00, 1'h1);
    s = r[15:8];
  endtask : sr

  task automatic rdchk(input logic [15:0] ad, input int n);
    for (int i = 0; i < n; i++)
    begin
      if (i % 4 == 0) apb(1'h0, 12'h020 + 12'(i), 32'h0);
      chk(32'(r[8 * (i % 4) +: 8]), 32'(em[16'(ad + 16'(i))]));
    end
    apb(1'h0, 12'h004, 32'h0);
    chk(r & 32'hFFFF, 32'(16'(ad + 16'(n))));
    chk(32'(spi_out.select_n), 32'h1);
  endtask : rdchk

  task automatic rdarr(input logic [15:0] ad, input int n);
    apb(1'h1, 12'h004, {16'h0, ad});
    run(3'h4, 5'(n - 1), 1'h1);
    rdchk(ad, n);
  endtask : rdarr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    #2ms;
    failures++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(2));
    for (int i = 0; i < 65536; i++)
      em[i] = 8'(i) ^ 8'(i >> 8);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'h0, 12'h008, 32'h0);
    chk(r & 32'h6, 32'h0);
    run(3'h2, 5'h00, 1'h0);
    repeat (10) @(posedge pclk);
    chk(32'(spi_out.select_n), 32'h1);
    repeat (60) @(posedge pclk);
    apb(1'h0, 12'h008, 32'h0);
    chk(r & 32'h6, 32'h6);
    sr;
    chk(32'(s), 32'h00);
    run(3'h0, 5'h00, 1'h1);
    sr;
    chk(32'(s), 32'h02);
    run(3'h1, 5'h00, 1'h1);
    sr;
    chk(32'(s), 32'h00);
    apb(1'h1, 12'h004, 32'h00FF_0000);
    run(3'h3, 5'h00, 1'h1);
    sr;
    chk(32'(s), 32'hFF);
    repeat (2400) @(posedge pclk);
    sr;
    chk(32'(s), 32'h8C);
    a = 16'($urandom) & 16'hFFE0;
    for (int w = 0; w < 8; w++)
    begin
      v = $urandom;
      for (int k = 0; k < 4; k++)
        em[a + 16'(4 * w + k)] = v[8 * k +: 8];
      apb(1'h1, 12'h020 + 12'(4 * w), v);
    end
    apb(1'h1, 12'h004, {16'h0, a | 16'h0013});
    run(3'h5, 5'h00, 1'h1);
    sr;
    chk(32'(s), 32'hFF);
    repeat (2400) @(posedge pclk);
    sr;
    chk(32'(s), 32'h8C);
    rdarr(a, 32);
    rdarr(16'hFFFE, 4);
    apb(1'h1, 12'h004, 32'h0000_1234);
    run(3'h4, 5'h01, 1'h0);
    repeat (700) @(posedge pclk);
    apb(1'h1, 12'h000, 32'h118);
    repeat (200) @(posedge pclk);
    chk(32'(spi_out.pause_n), 32'h0);
    chk(32'(spi_out.sck), 32'h0);
    repeat (400) @(posedge pclk);
    chk(32'(spi_out.sck), 32'h0);
    apb(1'h1, 12'h000, 32'h108);
    do
      apb(1'h0, 12'h008, 32'h0);
    while (r[3] !== 1'b1);
    rdchk(16'h1234, 2);
    repeat (100) @(posedge pclk);
    repeat (3)
      rdarr(16'($urandom), 1 + $urandom % 4);
    apb(1'h0, 12'h100, 32'h0);
    chk({31'h0, e}, 32'h1);
    end_of_test();
  end
endmodule : tb_top
